/* File: trs_consts.svh */
// Timing, offset and command constants of the timing/reset/step block.
// Assumes inclusion by bare name from the block's design files.
`ifndef TRS_CONSTS_SVH
`define TRS_CONSTS_SVH

`define TRS_OSC_DIV        2'd3
`define TRS_DIV_LAST       2'd2
`define TRS_STATES         3'd5
`define TRS_STATE_LAST     3'd4
`define TRS_STATE_FETCH    3'd0
`define TRS_STATE_PC       3'd1
`define TRS_RESET_CYCLES   5
`define TRS_REF_PERIOD_NS  50
`define TRS_INT_ROM_WORDS  12'h400

`define TRS_REG_CMD        4'h0
`define TRS_REG_STATUS     4'h4
`define TRS_REG_CONFIG     4'h8

`define TRS_CMD_CLK_OUT    5'h01
`define TRS_CMD_EN_XI      5'h02
`define TRS_CMD_DIS_XI     5'h03
`define TRS_CMD_EN_TI      5'h04
`define TRS_CMD_DIS_TI     5'h05
`define TRS_CMD_START_TMR  5'h06
`define TRS_CMD_START_CNT  5'h07
`define TRS_CMD_STOP       5'h08
`define TRS_CMD_CLR_F0     5'h09
`define TRS_CMD_CPL_F0     5'h0a
`define TRS_CMD_CLR_F1     5'h0b
`define TRS_CMD_CPL_F1     5'h0c
`define TRS_CMD_RB0        5'h0d
`define TRS_CMD_RB1        5'h0e
`define TRS_CMD_TEST_TF    5'h0f
`define TRS_CMD_MB0        5'h10
`define TRS_CMD_MB1        5'h11

`endif

/* File: trs_pkg.sv */
// Types shared by the timing/reset/step block.
// Assumes trs_consts.svh holds the numeric constants.
package trs_pkg;
  typedef enum logic {TRS_RUN, TRS_HALT} trs_step_state_t;
  typedef logic [2:0]  trs_state_idx_t;
  typedef logic [11:0] trs_addr_t;
  typedef logic [7:0]  trs_data_t;
  typedef logic [3:0]  trs_reg_addr_t;
  typedef logic [4:0]  trs_cmd_t;
endpackage

/* File: trs_timing_if.sv */
// Carrier for state timing between divider and step control.
// Assumes one clock domain, ref_clk_i.
`timescale 1ns/1ps
`default_nettype none
interface trs_timing_if;
  import trs_pkg::*;
  logic           state_en;
  trs_state_idx_t state_idx;
  logic           cycle_end;
  logic           hold;
  modport gen  (output state_en, state_idx, cycle_end, input hold);
  modport sink (input state_en, state_idx, cycle_end, output hold);
endinterface
`default_nettype wire

/* File: trs_clock_div.sv */
// Divides the reference into state enables and a five-state cycle.
// Assumes ref_clk_i is the oscillator output; hold freezes state S1.
`timescale 1ns/1ps
`default_nettype none
`include "trs_consts.svh"
module trs_clock_div (
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  output var  logic state_clk_o,
  trs_timing_if.gen tim
);
  import trs_pkg::*;
  logic [1:0]     div_r;
  trs_state_idx_t idx_r;
  logic           wrap_div;
  logic           wrap_idx;

  assign wrap_div      = (div_r == `TRS_DIV_LAST);
  assign wrap_idx      = (idx_r == `TRS_STATE_LAST);
  assign tim.state_en  = wrap_div;
  assign tim.state_idx = idx_r;
  assign tim.cycle_end = wrap_div & wrap_idx;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      div_r       <= 2'h0;
      state_clk_o <= 1'b0;
    end else begin
      div_r       <= wrap_div ? 2'h0 : div_r + 2'h1;
      state_clk_o <= wrap_div;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      idx_r <= 3'h0;
    end else if (wrap_div) begin
      if (wrap_idx)
        idx_r <= 3'h0;
      else if (!(tim.hold && idx_r == `TRS_STATE_FETCH))
        idx_r <= idx_r + 3'h1;
    end
  end

  AST_DIV_THREE:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
    tim.state_en |=> !tim.state_en ##1 !tim.state_en ##1 tim.state_en)
    else $error("state enable not every third reference cycle");
  AST_FIVE_STATES:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (tim.state_en && idx_r == 3'h0 && !tim.hold) |-> ##12
    (tim.state_en && idx_r == 3'h4))
    else $error("machine cycle is not five states");
endmodule // trs_clock_div
`default_nettype wire

/* File: trs_step_ctl.sv */
// Single-step halt control at instruction boundaries.
// Assumes step request is already synchronised to ref_clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "trs_consts.svh"
module trs_step_ctl (
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  input  wire logic core_rst_i,
  input  wire logic step_req_n_i,
  input  wire logic last_cycle_i,
  output var  logic halted_o,
  trs_timing_if.sink tim
);
  import trs_pkg::*;
  trs_step_state_t st_r;
  trs_step_state_t st_nxt;
  logic            stop_now;
  logic            resume_now;

  // Stop only after the last cycle of the running instruction
  assign stop_now   = tim.cycle_end & last_cycle_i & ~step_req_n_i;
  assign resume_now = tim.state_en & step_req_n_i;
  assign tim.hold   = (st_r == TRS_HALT);

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      TRS_RUN:  if (stop_now) st_nxt = TRS_HALT;
      TRS_HALT: if (resume_now) st_nxt = TRS_RUN;
      default:  st_nxt = TRS_RUN;
    endcase
    if (core_rst_i)
      st_nxt = TRS_RUN;
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r     <= TRS_RUN;
      halted_o <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      halted_o <= (st_nxt == TRS_HALT);
    end
  end

  AST_HALT_ENTRY:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (st_r == TRS_RUN && stop_now && !core_rst_i) |=> halted_o)
    else $error("no halt after last cycle with step request low");
endmodule // trs_step_ctl
`default_nettype wire

/* File: trs_top.sv */
// Timing, reset initialisation, single-step and fetch-select block.
// Assumes core logic on ref_clk_i; reset pin, step request and fetch
// select arrive from outside and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "trs_consts.svh"

module trs_top #(
  parameter trs_pkg::trs_addr_t INT_ROM_WORDS = `TRS_INT_ROM_WORDS
) (
  input  wire logic                   ref_clk_i,
  input  wire logic                   reset_i,
  input  wire logic                   reset_pin_n_i,
  input  wire logic                   step_req_n_i,
  input  wire logic                   external_fetch_select_i,
  input  wire logic                   last_cycle_i,
  input  wire trs_pkg::trs_addr_t     next_addr_i,
  input  wire logic                   timer_overflow_i,
  input  wire trs_pkg::trs_reg_addr_t reg_addr_i,
  input  wire trs_pkg::trs_data_t     reg_wdata_i,
  input  wire logic                   reg_we_i,
  input  wire logic                   reg_re_i,
  output var  trs_pkg::trs_data_t     reg_rdata_o,
  output var  logic                   cycle_strobe_o,
  output var  logic                   first_test_pin_o,
  output var  logic                   first_test_pin_oe_n_o,
  output var  trs_pkg::trs_state_idx_t state_idx_o,
  output var  logic                   core_init_o,
  output var  trs_pkg::trs_data_t     bus_o,
  output var  logic                   bus_oe_n_o,
  output var  logic [3:0]             p2_low_o,
  output var  logic                   p2_low_oe_n_o,
  output var  logic                   port_input_mode_o,
  output var  logic                   ram_access_en_o,
  output var  logic                   ext_fetch_o,
  output var  logic                   halted_o,
  output var  logic                   timer_run_o,
  output var  logic                   timer_count_mode_o,
  output var  logic                   timer_int_en_o,
  output var  logic                   ext_int_en_o,
  output var  logic                   timer_ovf_flag_o,
  output var  logic                   user_flag_zero_o,
  output var  logic                   user_flag_one_o,
  output var  logic                   reg_bank_o,
  output var  logic                   mem_bank_o
);
  import trs_pkg::*;

  trs_timing_if tim ();

  // Pin synchronisers: reset pin, step request, fetch select
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic       rst_pin_s;
  logic       step_n_s;
  logic       ext_sel_s;
  logic       core_rst;
  logic       state_clk;
  logic       halted;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_r <= 3'h2;
      sync2_r <= 3'h2;
    end else begin
      sync1_r <= {external_fetch_select_i, step_req_n_i, reset_pin_n_i};
      sync2_r <= sync1_r;
    end
  end

  assign rst_pin_s = sync2_r[0];
  assign step_n_s  = sync2_r[1];
  assign ext_sel_s = sync2_r[2];
  // Initialisation is applied on every cycle the pin is low
  assign core_rst  = ~rst_pin_s;

  trs_clock_div u_div (
    .ref_clk_i   (ref_clk_i),
    .reset_i     (reset_i),
    .state_clk_o (state_clk),
    .tim         (tim.gen)
  );

  trs_step_ctl u_step (
    .ref_clk_i    (ref_clk_i),
    .reset_i      (reset_i),
    .core_rst_i   (core_rst),
    .step_req_n_i (step_n_s),
    .last_cycle_i (last_cycle_i),
    .halted_o     (halted),
    .tim          (tim.sink)
  );

  assign state_idx_o = tim.state_idx;
  assign halted_o    = halted;

  // Command decode from the register port
  function automatic logic cmd_is(input trs_cmd_t code);
    cmd_is = reg_we_i && (reg_addr_i == `TRS_REG_CMD) &&
             (reg_wdata_i[4:0] == code);
  endfunction

  logic clk_out_en_r;
  logic clk_out_en_nxt;
  logic tf_nxt;
  logic xi_nxt;
  logic ti_nxt;
  logic run_nxt;
  logic cnt_nxt;
  logic f0_nxt;
  logic f1_nxt;
  logic rb_nxt;
  logic mb_nxt;

  assign clk_out_en_nxt = core_rst ? 1'b0 :
                          (cmd_is(`TRS_CMD_CLK_OUT) | clk_out_en_r);
  // Overflow that lands with the test-and-clear still sets the flag
  assign tf_nxt  = core_rst ? 1'b0 :
                   (timer_overflow_i |
                    (timer_ovf_flag_o & ~cmd_is(`TRS_CMD_TEST_TF)));
  assign xi_nxt  = core_rst ? 1'b0 :
                   cmd_is(`TRS_CMD_EN_XI) ? 1'b1 :
                   cmd_is(`TRS_CMD_DIS_XI) ? 1'b0 : ext_int_en_o;
  assign ti_nxt  = core_rst ? 1'b0 :
                   cmd_is(`TRS_CMD_EN_TI) ? 1'b1 :
                   cmd_is(`TRS_CMD_DIS_TI) ? 1'b0 : timer_int_en_o;
  assign run_nxt = core_rst ? 1'b0 :
                   (cmd_is(`TRS_CMD_START_TMR) |
                    cmd_is(`TRS_CMD_START_CNT)) ? 1'b1 :
                   cmd_is(`TRS_CMD_STOP) ? 1'b0 : timer_run_o;
  assign cnt_nxt = cmd_is(`TRS_CMD_START_CNT) ? 1'b1 :
                   cmd_is(`TRS_CMD_START_TMR) ? 1'b0 : timer_count_mode_o;
  assign f0_nxt  = core_rst ? 1'b0 :
                   cmd_is(`TRS_CMD_CLR_F0) ? 1'b0 :
                   cmd_is(`TRS_CMD_CPL_F0) ? ~user_flag_zero_o :
                   user_flag_zero_o;
  assign f1_nxt  = core_rst ? 1'b0 :
                   cmd_is(`TRS_CMD_CLR_F1) ? 1'b0 :
                   cmd_is(`TRS_CMD_CPL_F1) ? ~user_flag_one_o :
                   user_flag_one_o;
  assign rb_nxt  = core_rst ? 1'b0 :
                   cmd_is(`TRS_CMD_RB1) ? 1'b1 :
                   cmd_is(`TRS_CMD_RB0) ? 1'b0 : reg_bank_o;
  assign mb_nxt  = core_rst ? 1'b0 :
                   cmd_is(`TRS_CMD_MB1) ? 1'b1 :
                   cmd_is(`TRS_CMD_MB0) ? 1'b0 : mem_bank_o;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      clk_out_en_r       <= 1'b0;
      timer_ovf_flag_o   <= 1'b0;
      ext_int_en_o       <= 1'b0;
      timer_int_en_o     <= 1'b0;
      timer_run_o        <= 1'b0;
      timer_count_mode_o <= 1'b0;
      user_flag_zero_o   <= 1'b0;
      user_flag_one_o    <= 1'b0;
      reg_bank_o         <= 1'b0;
      mem_bank_o         <= 1'b0;
    end else begin
      clk_out_en_r       <= clk_out_en_nxt;
      timer_ovf_flag_o   <= tf_nxt;
      ext_int_en_o       <= xi_nxt;
      timer_int_en_o     <= ti_nxt;
      timer_run_o        <= run_nxt;
      timer_count_mode_o <= cnt_nxt;
      user_flag_zero_o   <= f0_nxt;
      user_flag_one_o    <= f1_nxt;
      reg_bank_o         <= rb_nxt;
      mem_bank_o         <= mb_nxt;
    end
  end

  // Fetch routing, strobe, pins and bus
  logic ext_fetch_nxt;
  logic addr_drive;
  logic bus_drive;

  assign ext_fetch_nxt = ext_sel_s | (next_addr_i >= INT_ROM_WORDS);
  // Address is placed on the bus in the program counter update state
  assign addr_drive = ext_fetch_o & ~core_rst &
                      (tim.state_idx == `TRS_STATE_PC);
  // Halt address overwrites whatever the bus buffer held
  assign bus_drive  = halted | addr_drive | (core_rst & ext_sel_s);

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cycle_strobe_o        <= 1'b0;
      first_test_pin_o      <= 1'b0;
      first_test_pin_oe_n_o <= 1'b1;
      core_init_o           <= 1'b1;
      ext_fetch_o           <= 1'b0;
      port_input_mode_o     <= 1'b1;
      ram_access_en_o       <= 1'b0;
    end else begin
      cycle_strobe_o <= halted | (tim.state_idx == `TRS_STATE_LAST);
      // Next value, so a reset turns the pin off at once
      first_test_pin_o      <= state_clk & clk_out_en_nxt;
      first_test_pin_oe_n_o <= ~clk_out_en_nxt;
      core_init_o           <= core_rst;
      ext_fetch_o           <= ext_fetch_nxt;
      port_input_mode_o     <= core_rst;
      ram_access_en_o       <= ~core_rst;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      bus_o         <= 8'h00;
      bus_oe_n_o    <= 1'b1;
      p2_low_o      <= 4'h0;
      p2_low_oe_n_o <= 1'b1;
    end else begin
      bus_o         <= core_rst ? 8'h00 : next_addr_i[7:0];
      bus_oe_n_o    <= ~bus_drive;
      p2_low_o      <= core_rst ? 4'h0 : next_addr_i[11:8];
      p2_low_oe_n_o <= ~bus_drive;
    end
  end

  // Register read port: data valid in the cycle after the strobe only
  trs_data_t status_w;
  trs_data_t config_w;
  trs_data_t rd_mux;

  assign status_w = {halted, ext_sel_s, clk_out_en_r, timer_ovf_flag_o,
                     user_flag_one_o, user_flag_zero_o, timer_run_o,
                     timer_int_en_o};
  assign config_w = {ext_int_en_o, timer_count_mode_o, reg_bank_o,
                     mem_bank_o, ext_fetch_o, tim.state_idx};
  assign rd_mux   = (reg_addr_i == `TRS_REG_STATUS) ? status_w :
                    (reg_addr_i == `TRS_REG_CONFIG) ? config_w : 8'h00;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i)
      reg_rdata_o <= 8'h00;
    else
      reg_rdata_o <= reg_re_i ? rd_mux : 8'h00;
  end

  AST_CLK_OUT_OFF:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
    core_rst |=> first_test_pin_oe_n_o && !first_test_pin_o)
    else $error("state clock output not off under reset");
  AST_CLK_OUT_CMD:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (!clk_out_en_r && !cmd_is(`TRS_CMD_CLK_OUT)) |=> first_test_pin_oe_n_o)
    else $error("state clock driven without enable command");
  AST_STROBE_RUN:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (tim.cycle_end && !halted) |-> cycle_strobe_o ##1 cycle_strobe_o
    ##1 (!cycle_strobe_o || halted))
    else $error("cycle strobe missing in last state");
  AST_HALT_SHOW:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (halted && $past(halted)) |-> (cycle_strobe_o && !bus_oe_n_o &&
    !p2_low_oe_n_o && bus_o == $past(next_addr_i[7:0])))
    else $error("halt does not show strobe high and next address");
  AST_EXIT_LOW:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ($fell(halted) && !core_rst) |=> !cycle_strobe_o)
    else $error("strobe not low after leaving halt");
  AST_RAM_BLOCK:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
    core_rst |=> !ram_access_en_o)
    else $error("data RAM access open under reset");
  AST_RESET_STATE:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
    core_rst |=> (!timer_run_o && !timer_ovf_flag_o && !timer_int_en_o &&
    !ext_int_en_o && !user_flag_zero_o && !user_flag_one_o &&
    !reg_bank_o && !mem_bank_o && core_init_o))
    else $error("reset state not applied");
  AST_RESET_BUS:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (core_rst && !halted) |=> (bus_oe_n_o == !$past(ext_sel_s)) &&
    port_input_mode_o)
    else $error("bus or ports wrong under reset");
  AST_EXT_FETCH:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ext_sel_s |=> ext_fetch_o)
    else $error("fetch select high but fetch not external");
  AST_OVF_SET:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (timer_overflow_i && !core_rst) |=> timer_ovf_flag_o)
    else $error("timer overflow did not set its flag");
  AST_ADDR_PC:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (ext_fetch_o && !core_rst && tim.state_idx == `TRS_STATE_PC)
    |=> !bus_oe_n_o && !p2_low_oe_n_o)
    else $error("fetch address not driven in counter state");
endmodule // trs_top
`default_nettype wire

/* File: trs_far_end.sv */
// Model of the reset source and the single-step flip-flop.
// Assumes the bench drives the requests on ref_clk_i.
`timescale 1ns/1ps
`default_nettype none
module trs_far_end #(
  parameter int HOLD = 75
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_req_i,
  input  wire logic sel_i,
  input  wire logic run_i,
  input  wire logic step_i,
  input  wire logic cycle_strobe_i,
  output logic      reset_pin_n_o,
  output logic      sel_o,
  output logic      step_req_n_o
);
  int   cnt_r = HOLD;
  logic sel_r = 1'b0;
  logic req_r = 1'b1;
  // Pin stays low for a full hold span after each request
  always @(posedge ref_clk_i) begin
    if (rst_req_i) begin
      cnt_r <= HOLD;
    end else if (cnt_r != 0) begin
      cnt_r <= cnt_r - 1;
    end
    if (cnt_r != 0) begin
      sel_r <= sel_i;
    end
    // Preset wins; a low strobe clears; a step clocks in a one
    if (run_i) begin
      req_r <= 1'b1;
    end else if (cycle_strobe_i !== 1'b1) begin
      req_r <= 1'b0;
    end else if (step_i) begin
      req_r <= 1'b1;
    end
  end
  assign reset_pin_n_o = (cnt_r == 0);
  assign sel_o         = sel_r;
  assign step_req_n_o  = req_r;
endmodule // trs_far_end
`default_nettype wire

/* File: timing_reset_single_step_test.sv */
// Self-checking bench of the timing, reset and single-step block.
// Assumes trs_top and trs_far_end; the bench stands in for the core.
`timescale 1ns/1ps
`default_nettype none
`include "trs_consts.svh"
module timing_reset_single_step_test;
  import trs_pkg::*;
  logic ref_clk_i;
  logic reset_i = 1'b1;
  logic rst_req = 1'b0;
  logic sel = 1'b0;
  logic run = 1'b1;
  logic step = 1'b0;
  logic last_cycle = 1'b1;
  logic tovf_in = 1'b0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic msel = 1'b0;
  trs_addr_t next_addr = '0;
  trs_reg_addr_t addr = '0;
  trs_data_t wdata = '0;
  trs_data_t rdata, bus;
  trs_state_idx_t sidx;
  logic [3:0] p2;
  logic pin_n, sel_s, req_n, cs, tp, tp_oe_n, ci, bus_oe_n, p2_oe_n, pim;
  logic ram_en, xf, hlt, trun, tcm, tie, xie, tovf, uf0, uf1, rb, mb;
  logic [31:0] seed = 32'hd047129b;
  bit [9:0] m = '0;
  int ix[18] = '{0,5,9,9,0,0,1,1,1,2,2,3,3,7,7,4,6,6};
  int vl[18] = '{0,1,1,0,1,0,1,1,0,0,2,0,2,0,1,0,0,1};
  int bad_count = 0;
  int checks = 0;

  trs_far_end #(.HOLD(75)) i_far (.ref_clk_i(ref_clk_i),
    .rst_req_i(rst_req), .sel_i(sel), .run_i(run), .step_i(step),
    .cycle_strobe_i(cs), .reset_pin_n_o(pin_n), .sel_o(sel_s),
    .step_req_n_o(req_n));

  trs_top i_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .reset_pin_n_i(pin_n), .step_req_n_i(req_n),
    .external_fetch_select_i(sel_s), .last_cycle_i(last_cycle),
    .next_addr_i(next_addr), .timer_overflow_i(tovf_in),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we),
    .reg_re_i(re), .reg_rdata_o(rdata), .cycle_strobe_o(cs),
    .first_test_pin_o(tp), .first_test_pin_oe_n_o(tp_oe_n),
    .state_idx_o(sidx), .core_init_o(ci), .bus_o(bus),
    .bus_oe_n_o(bus_oe_n), .p2_low_o(p2), .p2_low_oe_n_o(p2_oe_n),
    .port_input_mode_o(pim), .ram_access_en_o(ram_en),
    .ext_fetch_o(xf), .halted_o(hlt), .timer_run_o(trun),
    .timer_count_mode_o(tcm), .timer_int_en_o(tie),
    .ext_int_en_o(xie), .timer_ovf_flag_o(tovf),
    .user_flag_zero_o(uf0), .user_flag_one_o(uf1),
    .reg_bank_o(rb), .mem_bank_o(mb));

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic wr(input trs_reg_addr_t a, input trs_data_t d);
    @(posedge ref_clk_i);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk_i);
    we <= 1'b0;
  endtask

  task automatic rd(input trs_reg_addr_t a, output trs_data_t d);
    @(posedge ref_clk_i);
    re <= 1'b1;
    addr <= a;
    @(posedge ref_clk_i);
    re <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wait_halt(input logic want, input int lim);
    int n = 0;
    while (hlt !== want && n < lim) begin
      tick(1);
      n++;
    end
    chk(hlt === want, "halt state");
  endtask

  // Reset pin held for five machine cycles, fetch select set meanwhile
  task automatic pin_reset(input logic s);
    @(posedge ref_clk_i);
    sel <= s;
    rst_req <= 1'b1;
    @(posedge ref_clk_i);
    rst_req <= 1'b0;
    tick(10);
    chk(ci === 1'b1 && ram_en === 1'b0 && pim === 1'b1, "held");
    chk(bus_oe_n === !s && tp_oe_n === 1'b1, "bus, clock pin");
    chk({trun, tie, xie, tovf, uf0, uf1, rb, mb} === 8'h00, "flags");
    tick(80);
    chk(ci === 1'b0 && ram_en === 1'b1, "released");
    m = m & 10'h100;
    msel = s;
  endtask

  task automatic div_test;
    int hi = 0;
    int rise = 0;
    int chg = 0;
    logic ps;
    trs_state_idx_t pi;
    tick(1);
    ps = cs;
    pi = sidx;
    repeat (150) begin
      tick(1);
      hi += cs;
      rise += (cs === 1'b1 && ps === 1'b0);
      if (sidx !== pi) begin
        chg++;
        chk(sidx === ((pi == 3'd4) ? 3'd0 : pi + 3'd1), "state order");
      end
      ps = cs;
      pi = sidx;
    end
    chk(chg == 50 && rise == 10 && hi == 30, "divider rates");
  endtask

  task automatic clk_test;
    int hi = 0;
    chk(tp_oe_n === 1'b1, "clock pin off");
    wr(4'h0, 8'h01);
    m[5] = 1'b1;
    tick(2);
    chk(tp_oe_n === 1'b0, "clock pin on");
    repeat (30) begin
      tick(1);
      hi += tp;
    end
    chk(hi == 10, "state clock on pin");
  endtask

  task automatic reg_loop(input int n);
    logic [31:0] r;
    trs_data_t d;
    int c;
    repeat (n) begin
      r = rnd();
      c = int'(r[4:0]);
      @(posedge ref_clk_i);
      next_addr <= r[27:16];
      tovf_in <= r[5];
      m[4] = m[4] | r[5];
      @(posedge ref_clk_i);
      tovf_in <= 1'b0;
      wr(r[6] ? 4'h4 : 4'h0, {3'b000, r[4:0]});
      if (!r[6] && c >= 1 && c <= 17)
        m[ix[c]] = (vl[c] == 2) ? ~m[ix[c]] : vl[c][0];
      if (!r[6] && (c == 6 || c == 7))
        m[8] = c[0];
      rd(4'h4, d);
      chk(d === {1'b0, msel, m[5:0]}, "status");
      rd(4'h8, d);
      chk(d[7:3] === {m[9:6], msel | (r[27:16] >= `TRS_INT_ROM_WORDS)},
          "config");
      rd(r[7] ? 4'hc : 4'h0, d);
      chk(d === 8'h00, "unmapped read");
    end
  endtask

  task automatic step_test;
    trs_state_idx_t s0;
    trs_data_t d;
    int n = 0;
    logic [31:0] r;
    r = rnd();
    @(posedge ref_clk_i);
    next_addr <= r[11:0];
    last_cycle <= 1'b0;
    run <= 1'b0;
    tick(60);
    chk(hlt === 1'b0, "no halt mid-instruction");
    @(posedge ref_clk_i);
    last_cycle <= 1'b1;
    wait_halt(1'b1, 40);
    tick(2);
    s0 = sidx;
    repeat (8) begin
      chk(cs === 1'b1 && sidx === s0 && hlt === 1'b1, "held stop");
      chk({bus_oe_n, p2_oe_n, p2, bus} === {2'b00, next_addr}, "addr");
      tick(1);
    end
    rd(4'h4, d);
    chk(d[7] === 1'b1, "halt status");
    @(posedge ref_clk_i);
    step <= 1'b1;
    @(posedge ref_clk_i);
    step <= 1'b0;
    wait_halt(1'b0, 20);
    tick(1);
    chk(cs === 1'b0, "strobe falls on exit");
    wait_halt(1'b1, 40);
    @(posedge ref_clk_i);
    run <= 1'b1;
    wait_halt(1'b0, 20);
    repeat (60) begin
      tick(1);
      n += hlt;
    end
    chk(n == 0, "run mode keeps running");
  endtask

  task automatic addr_test;
    int hit = 0;
    repeat (15) begin
      tick(1);
      hit += (sidx === 3'd1 && bus_oe_n === 1'b0 && p2_oe_n === 1'b0
              && {p2, bus} === next_addr);
    end
    chk(hit > 0, "fetch address in state two");
  endtask

  initial begin
    repeat (10) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    tick(90);
    pin_reset(1'b0);
    div_test();
    $display("divider test done");
    clk_test();
    $display("clock pin test done");
    reg_loop(30);
    $display("register test done");
    step_test();
    $display("single step test done");
    pin_reset(1'b1);
    addr_test();
    reg_loop(20);
    $display("fetch select test done");
    pin_reset(1'b0);
    test_done();
  end

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    bad_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end
endmodule // timing_reset_single_step_test
`default_nettype wire
